/* File: include/delsc_params.svh */
// Offsets, field positions and reset values of the DMA event capture block
// Assumes an 8-bit APB byte address decoded by the top module
`ifndef DELSC_PARAMS_SVH
`define DELSC_PARAMS_SVH

`define DELSC_ADDR_W          8
`define DELSC_DATA_W          32
`define DELSC_CH_W            5
`define DELSC_MAX_CH          32

`define DELSC_OFF_PENDING     8'h00
`define DELSC_OFF_CLEAR       8'h08
`define DELSC_OFF_SWTRIG      8'h10
`define DELSC_OFF_GATE        8'h18
`define DELSC_OFF_LOST        8'h20
`define DELSC_OFF_LOST_CLR    8'h28
`define DELSC_OFF_IRQ_STAT    8'h30
`define DELSC_OFF_IRQ_EN      8'h34
`define DELSC_OFF_IRQ_CLR     8'h38

`define DELSC_IRQ_W           2
`define DELSC_IRQ_LOST_BIT    0
`define DELSC_IRQ_SUBMIT_BIT  1

`define DELSC_RST_CHAN        32'h00000000
`define DELSC_RST_IRQ         2'h0
`define DELSC_RST_WORD        32'h00000000

`endif

/* File: include/delsc_pkg.sv */
// Types shared by the DMA event capture block
// Assumes delsc_params.svh for widths
`include "delsc_params.svh"

package delsc_pkg;

   typedef logic [`DELSC_DATA_W-1:0] delsc_word_t;

   // Submission handshake toward the transfer controllers
   typedef enum logic [0:0] {
      DELSC_IDLE = 1'b0,
      DELSC_REQ  = 1'b1
   } delsc_arb_state_t;

endpackage

/* File: design/delsc_sync.sv */
// Two-flop synchronisers and rising-edge pulses for the event pins
// Assumes pins asynchronous to clock; each pulse lasts one cycle
`timescale 1ns/1ps
`default_nettype none

module delsc_sync
   import delsc_pkg::*;
#(
   parameter int N = 32
) (
   input  wire logic         clock,
   input  wire logic         rst,
   input  wire logic [N-1:0] pinIn,
   output logic      [N-1:0] risePulse
);

   logic [N-1:0] meta_r;
   logic [N-1:0] sync_r;
   logic [N-1:0] prev_r;

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : gSync
         always_ff @(posedge clock) begin
            if (rst) begin
               meta_r[g] <= 1'b0;
               sync_r[g] <= 1'b0;
               prev_r[g] <= 1'b0;
            end else begin
               meta_r[g] <= pinIn[g];
               sync_r[g] <= meta_r[g];
               prev_r[g] <= sync_r[g];
            end
         end
         // Edge taken after the second flop only
         assign risePulse[g] = sync_r[g] & ~prev_r[g];
      end
   endgenerate

endmodule // delsc_sync

`default_nettype wire

/* File: design/delsc_arbiter.sv */
// Picks the lowest pending eligible channel and offers it to the transfer side
// Assumes trReady from same-clock logic; request held until taken
`timescale 1ns/1ps
`default_nettype none

module delsc_arbiter
   import delsc_pkg::*;
#(
   parameter int N    = 32,
   parameter int CH_W = 5
) (
   input  wire logic            clock,
   input  wire logic            rst,
   input  wire logic [N-1:0]    eligible,
   input  wire logic            trReady,
   output logic                 trValid,
   output logic      [CH_W-1:0] trChannel,
   output logic      [N-1:0]    serviceAck
);

   delsc_arb_state_t state_r;
   logic [CH_W-1:0]  pick;
   logic             any;

   always_comb begin
      pick = '0;
      any  = 1'b0;
      for (int i = N - 1; i >= 0; i--) begin
         if (eligible[i]) begin
            pick = CH_W'(i);
            any  = 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_r   <= DELSC_IDLE;
         trValid   <= 1'b0;
         trChannel <= '0;
      end else begin
         unique case (state_r)
            DELSC_IDLE: begin
               if (any) begin
                  state_r   <= DELSC_REQ;
                  trValid   <= 1'b1;
                  trChannel <= pick;
               end
            end
            DELSC_REQ: begin
               if (trReady) begin
                  state_r <= DELSC_IDLE;
                  trValid <= 1'b0;
               end
            end
         endcase
      end
   end

   // One-cycle acknowledge at the accepting edge
   always_comb begin
      serviceAck = '0;
      if (state_r == DELSC_REQ && trReady) begin
         serviceAck[trChannel] = 1'b1;
      end
   end

endmodule // delsc_arbiter

`default_nettype wire

/* File: design/delsc_top.sv */
// DMA event capture: hardware latch, software trigger, lost flags, APB slave
// Assumes APB master and transfer controllers on clock; event pins asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "delsc_params.svh"

module delsc_top
   import delsc_pkg::*;
#(
   parameter int N = 32
) (
   input  wire logic                     clock,
   input  wire logic                     rst,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [`DELSC_ADDR_W-1:0] paddr,
   input  wire logic [`DELSC_DATA_W-1:0] pwdata,
   output logic      [`DELSC_DATA_W-1:0] prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire logic [N-1:0]             eventIn,
   output logic                          trValid,
   output logic      [`DELSC_CH_W-1:0]   trChannel,
   input  wire logic                     trReady,
   output logic                          irq
);

   localparam int CH_W = `DELSC_CH_W;

   generate
      if (N < 2 || N > `DELSC_MAX_CH) begin : gBadN
         $error("delsc_top: channel count out of range");
      end
   endgenerate

   // Channel state
   logic [N-1:0] latch_r;
   logic [N-1:0] latch_nxt;
   logic [N-1:0] swTrig_r;
   logic [N-1:0] swTrig_nxt;
   logic [N-1:0] gate_r;
   logic [N-1:0] lost_r;
   logic [N-1:0] lost_nxt;

   // Event and service pulses
   logic [N-1:0] hwEvt;
   logic [N-1:0] ack;
   logic [N-1:0] eligible;
   logic [N-1:0] clrStrobe;
   logic [N-1:0] swWr;
   logic [N-1:0] lostClr;
   logic [N-1:0] lostSet;

   // Interrupt state
   logic [`DELSC_IRQ_W-1:0] irqStat_r;
   logic [`DELSC_IRQ_W-1:0] irqStat_nxt;
   logic [`DELSC_IRQ_W-1:0] irqEn_r;
   logic [`DELSC_IRQ_W-1:0] irqSet;
   logic [`DELSC_IRQ_W-1:0] irqClr;

   // Bus decode
   logic        accSetup;
   logic        accDone;
   logic        wrHit;
   logic        selPend;
   logic        selClr;
   logic        selSw;
   logic        selGate;
   logic        selLost;
   logic        selLostClr;
   logic        selIrqStat;
   logic        selIrqEn;
   logic        selIrqClr;
   logic        mapped;
   delsc_word_t readMux;

   function automatic delsc_word_t padChan(input logic [N-1:0] v);
      delsc_word_t w;
      w        = `DELSC_RST_WORD;
      w[N-1:0] = v;
      return w;
   endfunction

   function automatic delsc_word_t padIrq(input logic [`DELSC_IRQ_W-1:0] v);
      delsc_word_t w;
      w                   = `DELSC_RST_WORD;
      w[`DELSC_IRQ_W-1:0] = v;
      return w;
   endfunction

   delsc_sync #(
      .N (N)
   ) uSync (
      .clock     (clock),
      .rst       (rst),
      .pinIn     (eventIn),
      .risePulse (hwEvt)
   );

   delsc_arbiter #(
      .N    (N),
      .CH_W (CH_W)
   ) uArb (
      .clock      (clock),
      .rst        (rst),
      .eligible   (eligible),
      .trReady    (trReady),
      .trValid    (trValid),
      .trChannel  (trChannel),
      .serviceAck (ack)
   );

   // One wait state keeps pready and prdata straight from flops
   assign accSetup = psel & penable & ~pready;
   assign accDone  = psel & penable & pready;
   assign wrHit    = accDone & pwrite;

   assign selPend    = (paddr == `DELSC_OFF_PENDING);
   assign selClr     = (paddr == `DELSC_OFF_CLEAR);
   assign selSw      = (paddr == `DELSC_OFF_SWTRIG);
   assign selGate    = (paddr == `DELSC_OFF_GATE);
   assign selLost    = (paddr == `DELSC_OFF_LOST);
   assign selLostClr = (paddr == `DELSC_OFF_LOST_CLR);
   assign selIrqStat = (paddr == `DELSC_OFF_IRQ_STAT);
   assign selIrqEn   = (paddr == `DELSC_OFF_IRQ_EN);
   assign selIrqClr  = (paddr == `DELSC_OFF_IRQ_CLR);
   assign mapped     = selPend | selClr | selSw | selGate | selLost |
                       selLostClr | selIrqStat | selIrqEn | selIrqClr;

   // Write strobes, bit n for channel n; irqClr bit n clears interrupt status bit n
   assign clrStrobe = (wrHit && selClr) ? pwdata[N-1:0] : '0;
   assign swWr      = (wrHit && selSw) ? pwdata[N-1:0] : '0;
   assign lostClr   = (wrHit && selLostClr) ? pwdata[N-1:0] : '0;
   assign irqClr    = (wrHit && selIrqClr) ? pwdata[`DELSC_IRQ_W-1:0] : '0;

   // Eligibility toward the arbiter
   assign eligible = (latch_r & gate_r) | swTrig_r;

   // Pending latch: set beats strobe clear and service clear
   always_comb begin
      latch_nxt = latch_r & ~(clrStrobe | ack);
      latch_nxt = latch_nxt | hwEvt;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         latch_r <= N'(`DELSC_RST_CHAN);
      end else begin
         latch_r <= latch_nxt;
      end
   end

   // Software trigger: blind to the clear strobe
   always_comb begin
      swTrig_nxt = swTrig_r & ~ack;
      swTrig_nxt = swTrig_nxt | swWr;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         swTrig_r <= N'(`DELSC_RST_CHAN);
      end else begin
         swTrig_r <= swTrig_nxt;
      end
   end

   // Gate mask written directly
   always_ff @(posedge clock) begin
      if (rst) begin
         gate_r <= N'(`DELSC_RST_CHAN);
      end else if (wrHit && selGate) begin
         gate_r <= pwdata[N-1:0];
      end
   end

   // Lost flags: a second event before service, hardware events counted on gated channels only
   assign lostSet = (hwEvt & latch_r & gate_r)
                  | (swWr & swTrig_r);

   always_comb begin
      lost_nxt = lost_r & ~lostClr;
      lost_nxt = lost_nxt | lostSet;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         lost_r <= N'(`DELSC_RST_CHAN);
      end else begin
         lost_r <= lost_nxt;
      end
   end

   // Interrupt status, sticky, set beats clear
   always_comb begin
      irqSet                        = '0;
      irqSet[`DELSC_IRQ_LOST_BIT]   = |lostSet;
      irqSet[`DELSC_IRQ_SUBMIT_BIT] = |ack;
      irqStat_nxt                   = (irqStat_r & ~irqClr) | irqSet;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         irqStat_r <= `DELSC_RST_IRQ;
      end else begin
         irqStat_r <= irqStat_nxt;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         irqEn_r <= `DELSC_RST_IRQ;
      end else if (wrHit && selIrqEn) begin
         irqEn_r <= pwdata[`DELSC_IRQ_W-1:0];
      end
   end

   // Level output, one cycle behind the status
   always_ff @(posedge clock) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irqStat_r & irqEn_r);
      end
   end

   // Read view; write-only words read as zero
   always_comb begin
      readMux = `DELSC_RST_WORD;
      if (selPend) begin
         readMux = padChan(latch_r);
      end else if (selSw) begin
         readMux = padChan(swTrig_r);
      end else if (selGate) begin
         readMux = padChan(gate_r);
      end else if (selLost) begin
         readMux = padChan(lost_r);
      end else if (selIrqStat) begin
         readMux = padIrq(irqStat_r);
      end else if (selIrqEn) begin
         readMux = padIrq(irqEn_r);
      end
   end

   // Bus answer
   always_ff @(posedge clock) begin
      if (rst) begin
         pready <= 1'b0;
      end else begin
         pready <= accSetup;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= accSetup & ~mapped;
      end
   end

   // Data sampled one cycle before completion
   always_ff @(posedge clock) begin
      if (rst) begin
         prdata <= `DELSC_RST_WORD;
      end else if (accSetup && !pwrite) begin
         prdata <= readMux;
      end else if (accDone) begin
         prdata <= `DELSC_RST_WORD;
      end
   end

endmodule // delsc_top

`default_nettype wire

/* File: sim/delsc_chk.sv */
// Port checker for the DMA event capture top
// Assumes rst synchronous active high on clock
`timescale 1ns/1ps
`default_nettype none
`include "delsc_params.svh"
module delsc_chk
   import delsc_pkg::*;
#(
   parameter int N = 32
) (
   input wire logic                     clock,
   input wire logic                     rst,
   input wire logic                     psel,
   input wire logic                     penable,
   input wire logic                     pwrite,
   input wire logic [`DELSC_ADDR_W-1:0] paddr,
   input wire logic [`DELSC_DATA_W-1:0] pwdata,
   input wire logic [`DELSC_DATA_W-1:0] prdata,
   input wire logic                     pready,
   input wire logic                     pslverr,
   input wire logic [N-1:0]             eventIn,
   input wire logic                     trValid,
   input wire logic [`DELSC_CH_W-1:0]   trChannel,
   input wire logic                     trReady,
   input wire logic                     irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("no ready after one wait state");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_err_reads_zero: assert property (pslverr |-> prdata == '0)
      else $error("error access returned data");
   a_req_held: assert property (trValid && !trReady |=> trValid && $stable(trChannel))
      else $error("request dropped or changed before accept");
   a_req_drops: assert property (trValid && trReady |=> !trValid)
      else $error("request stays after accept");
   a_swset_offer: assert property (psel && penable && pready && pwrite
      && paddr == `DELSC_OFF_SWTRIG && pwdata != '0 && !trValid |-> ##[1:3] trValid)
      else $error("software set never offered");
   a_chan_range: assert property (trValid |-> trChannel < N)
      else $error("channel outside range");
endmodule // delsc_chk
bind delsc_top delsc_chk #(.N(N)) u_delsc_chk (
   .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .eventIn(eventIn), .trValid(trValid),
   .trChannel(trChannel), .trReady(trReady), .irq(irq)
);
`default_nettype wire

/* File: sim/delsc_tr_model.sv */
// Transfer side model: accepts offered requests
// Assumes trValid held until accepted; stall from the bench
`timescale 1ns/1ps
`default_nettype none
module delsc_tr_model
   import delsc_pkg::*;
(
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic stall,
   input  wire logic trValid,
   output logic      trReady
);
   // Registered accept: one cycle after an offer, never without one
   always_ff @(posedge clock) begin
      if (rst) begin
         trReady <= 1'b0;
      end else begin
         trReady <= trValid && !trReady && !stall;
      end
   end
endmodule // delsc_tr_model
`default_nettype wire

/* File: sim/tb_top.sv */
// Bench for the DMA event capture top
// Assumes APB one wait state and the transfer model on the far side
`timescale 1ns/1ps
`default_nettype none
`include "delsc_params.svh"
module tb_top
   import delsc_pkg::*;
;
   logic        clock, rst, psel, penable, pwrite, pready, pslverr, err;
   logic        trValid, trReady, irq, stall;
   logic [7:0]  paddr;
   delsc_word_t pwdata, prdata, rd, eventIn;
   logic [4:0]  trChannel;
   logic [4:0]  got[$];
   logic [7:0]  regs[6] = '{8'h00, 8'h10, 8'h18, 8'h20, 8'h30, 8'h34};
   int          badCount, nChecks;

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   delsc_top #(.N(32)) u_delsc_top (
      .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .eventIn(eventIn), .trValid(trValid),
      .trChannel(trChannel), .trReady(trReady), .irq(irq));
   delsc_tr_model u_delsc_tr_model (.clock(clock), .rst(rst), .stall(stall),
      .trValid(trValid), .trReady(trReady));

   always @(posedge clock) if (trValid && trReady) got.push_back(trChannel);

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      nChecks++;
      if (g !== e) begin
         badCount++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, '0);
      chk(rd, e);
   endtask
   // Pin held 3 edges so the synchroniser sees a clean rise
   task automatic evt(input int n);
      eventIn[n] <= 1'b1;
      repeat (3) @(posedge clock);
      eventIn[n] <= 1'b0;
      repeat (4) @(posedge clock);
   endtask
   task automatic waitq(input int k);
      for (int t = 0; t < 40 && got.size() < k; t++) @(posedge clock);
   endtask
   task automatic results;
      $display("checks=%0d mismatches=%0d", nChecks, badCount);
      if (badCount == 0 && nChecks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      repeat (3000) @(posedge clock);
      badCount++;
      results();
   end

   initial begin
      {rst, psel, penable, pwrite, paddr, pwdata, eventIn, stall} = '0;
      rst = 1'b1;
      badCount = 0;
      nChecks = 0;
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      foreach (regs[i]) rc(regs[i], '0);
      rc(8'h04, '0);
      chk(32'(err), 1);
      evt(3);
      rc(`DELSC_OFF_PENDING, 32'h8);
      chk(got.size(), 0);
      evt(3);
      rc(`DELSC_OFF_LOST, '0);
      wr(`DELSC_OFF_CLEAR, '0);
      rc(`DELSC_OFF_PENDING, 32'h8);
      wr(`DELSC_OFF_CLEAR, 32'h8);
      rc(`DELSC_OFF_PENDING, '0);
      wr(`DELSC_OFF_SWTRIG, 32'h24);
      waitq(2);
      chk(got[0], 2);
      chk(got[1], 5);
      rc(`DELSC_OFF_SWTRIG, '0);
      stall <= 1'b1;
      wr(`DELSC_OFF_SWTRIG, 32'h80);
      wr(`DELSC_OFF_SWTRIG, 32'h80);
      rc(`DELSC_OFF_LOST, 32'h80);
      wr(`DELSC_OFF_CLEAR, 32'h80);
      rc(`DELSC_OFF_SWTRIG, 32'h80);
      wr(`DELSC_OFF_GATE, 32'h10);
      evt(4);
      evt(4);
      rc(`DELSC_OFF_LOST, 32'h90);
      rc(`DELSC_OFF_PENDING, 32'h10);
      chk(32'(irq), 0);
      wr(`DELSC_OFF_IRQ_EN, 32'h1);
      repeat (2) @(posedge clock);
      chk(32'(irq), 1);
      wr(`DELSC_OFF_IRQ_CLR, 32'h1);
      repeat (2) @(posedge clock);
      chk(32'(irq), 0);
      wr(`DELSC_OFF_LOST_CLR, 32'hFFFFFFFF);
      rc(`DELSC_OFF_LOST, '0);
      wr(`DELSC_OFF_IRQ_CLR, 32'h2);
      rc(`DELSC_OFF_IRQ_STAT, '0);
      wr(`DELSC_OFF_IRQ_EN, 32'h2);
      stall <= 1'b0;
      waitq(4);
      chk(got[2], 7);
      chk(got[3], 4);
      rc(`DELSC_OFF_PENDING, '0);
      rc(`DELSC_OFF_SWTRIG, '0);
      rc(`DELSC_OFF_IRQ_STAT, 32'h2);
      chk(32'(irq), 1);
      wr(`DELSC_OFF_IRQ_EN, '0);
      repeat (2) @(posedge clock);
      chk(32'(irq), 0);
      results();
   end
endmodule // tb_top
`default_nettype wire
